/* clkg_pkg.sv */
package clkg_pkg;
  // strap patterns that select the non-multiplying modes
  localparam logic [2:0] STRAP_PRESC = 3'h1;
  localparam logic [2:0] STRAP_DIRECT = 3'h3;
  // strap pattern for the x4 default; not used, the strap latch has no reset value
  localparam logic [2:0] STRAP_RST = 3'h7;
  // multiplier factors for each strap pattern
  localparam logic [3:0] FACT_X4 = 4'h4;
  localparam logic [3:0] FACT_X3 = 4'h3;
  localparam logic [3:0] FACT_X8 = 4'h8;
  localparam logic [3:0] FACT_X5 = 4'h5;
  localparam logic [3:0] FACT_X10 = 4'hA;
  // supervisor counter overflows after this many free-running cycles
  localparam logic [4:0] WDOG_OVF = 5'h10;
  // width and reset value of the multiplied half-unit length
  localparam int HALF_W = 8;
  localparam logic [7:0] HALF_RST = 8'h04;
  // half-unit length of the free-running backup clock, in system cycles
  localparam logic [7:0] FREE_HALF = 8'h01;
  // clock rate and lock-loss timeout
  localparam int CLK_PERIOD_NS = 10;
  localparam int UNLOCK_TIME_NS = 2000;
  localparam int UNLOCK_CYC = UNLOCK_TIME_NS / CLK_PERIOD_NS;
  localparam logic [7:0] UNLOCK_LIM = UNLOCK_CYC[7:0];
  // clock generation mechanism chosen by the straps
  typedef enum logic [1:0] {
    MODE_PLL = 2'h0,
    MODE_PRESC = 2'h1,
    MODE_DIRECT = 2'h3
  } clkg_mode_type;
  // source of the cpu clock: normal path or irrevocable backup
  typedef enum logic [1:0] {
    SRC_NORMAL = 2'h0,
    SRC_FREE = 2'h1
  } clkg_src_type;
endpackage : clkg_pkg

/* clkg_top.sv */
// Behaviour
// R1: sample strap pins during reset to pick mode
// R2: multiplier modes give input times factor F
// R3: strap 001 gives input divided by two
// R4: strap 011 drives cpu clock from input directly
// R5: all other strap patterns use the multiplier
// R6: resync every F transitions, adjust length gradually
// R7: supervisor on after reset, disable input stops it
// R8: supervisor works only in direct or prescaler mode
// R9: backup clock counts, input transitions clear counter
// R10: counter overflow after 16 cycles means failure
// R11: on failure use backup clock, raise request
// R12: backup clock kept until next reset
// R13: supervisor disabled: input clock, multiplier off
// R14: each cpu clock edge marks a half unit
// R15: prescaler phases each last one input period
// R16: direct phases follow input duty cycle
// R17: lock loss raises request, multiplier runs free
// R18: strap mode frozen after reset release
module clkg_top (
  // clock, reset, enable
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // crystal and straps from pins
  input wire logic crystal_input_pin_i,
  input wire logic [2:0] clock_mode_strap_pins_i,
  // configuration from the system configuration register
  input wire logic osc_supervisor_disable_i,
  // generated clock and half-unit marker
  output logic cpu_clk_o,
  output logic half_clock_unit_o,
  // analog controls
  output logic pll_enable_o,
  output logic osc_amp_enable_o,
  // latched mode and sticky requests
  output logic [1:0] clock_mode_o,
  output logic osc_fail_irq_o,
  output logic pll_unlock_irq_o
);

  // factor lookup for a strap pattern
  function automatic logic [3:0] strap_factor(input logic [2:0] s);
    case (s)
      3'h6: strap_factor = clkg_pkg::FACT_X3;
      3'h5: strap_factor = clkg_pkg::FACT_X8;
      3'h4: strap_factor = clkg_pkg::FACT_X5;
      3'h2: strap_factor = clkg_pkg::FACT_X10;
      default: strap_factor = clkg_pkg::FACT_X4;
    endcase
  endfunction : strap_factor

  // mode lookup for a strap pattern
  function automatic clkg_pkg::clkg_mode_type strap_mode(input logic [2:0] s);
    case (s)
      clkg_pkg::STRAP_PRESC: strap_mode = clkg_pkg::MODE_PRESC;
      clkg_pkg::STRAP_DIRECT: strap_mode = clkg_pkg::MODE_DIRECT;
      default: strap_mode = clkg_pkg::MODE_PLL;
    endcase
  endfunction : strap_mode

  // width of the multiplied half-unit length
  localparam int HALF_LOC = clkg_pkg::HALF_W;

  // pin synchronisers, three stages each
  logic [2:0] xs1_ff, xs2_ff, xs3_ff;
  logic [2:0] ss1_ff [3];
  logic xtal_lvl_ff; // filtered crystal level
  logic [2:0] strap_ff; // latched strap pattern
  clkg_pkg::clkg_mode_type mode_ff; // latched mode
  clkg_pkg::clkg_src_type src_ff; // clock source state
  logic [3:0] fact_ff; // latched factor
  logic [4:0] wdog_ff; // supervisor counter
  logic [7:0] nolock_ff; // cycles since last transition, multiplier mode
  logic [HALF_LOC-1:0] half_len_ff; // current multiplied half-unit length
  logic [7:0] unit_cnt_ff; // cycles within current half unit
  logic [7:0] win_units_ff; // half units in resync window
  logic [3:0] win_tr_ff; // transitions in resync window
  logic cpu_clk_ff, half_ff, pll_en_ff, amp_en_ff, osc_irq_ff, unl_irq_ff;

  // decoded conditions
  wire xtal_stable = xs2_ff[0] == xs3_ff[0];
  wire xtal_edge = xtal_stable && (xs3_ff[0] != xtal_lvl_ff);
  wire xtal_rise = xtal_edge && xs3_ff[0];
  wire is_pll = mode_ff == clkg_pkg::MODE_PLL;
  wire is_presc = mode_ff == clkg_pkg::MODE_PRESC;
  wire is_direct = mode_ff == clkg_pkg::MODE_DIRECT;
  wire normal = src_ff == clkg_pkg::SRC_NORMAL;
  wire sup_act = !osc_supervisor_disable_i && !is_pll; // see R7 see R8
  wire wdog_ovf = sup_act && normal && !xtal_edge
    && (wdog_ff == clkg_pkg::WDOG_OVF - 5'h01); // see R10
  wire lock_lost = is_pll && normal && !xtal_edge
    && (nolock_ff == clkg_pkg::UNLOCK_LIM); // see R17
  wire [7:0] fact_sq = 8'(fact_ff * fact_ff); // half units per window
  wire win_end = xtal_edge && (win_tr_ff == fact_ff - 4'h1); // see R6
  wire [7:0] cur_len = normal ? 8'(half_len_ff) : clkg_pkg::FREE_HALF;
  wire unit_done = unit_cnt_ff + 8'h01 >= cur_len;

  // next cpu clock per source and mode
  logic nxt_cpu_clk;
  assign nxt_cpu_clk = !normal ? (unit_done ? !cpu_clk_ff : cpu_clk_ff) // see R11
    : is_direct ? xtal_lvl_ff // see R4 see R16
    : is_presc ? (xtal_rise ? !cpu_clk_ff : cpu_clk_ff) // see R3 see R15
    : (unit_done ? !cpu_clk_ff : cpu_clk_ff); // see R2 see R5

  // next half-unit length, moved one step per window
  logic [HALF_LOC-1:0] nxt_half_len;
  assign nxt_half_len = !win_end ? half_len_ff
    : (win_units_ff < fact_sq && half_len_ff > 8'h01) ? half_len_ff - 8'h01
    : (win_units_ff > fact_sq) ? half_len_ff + 8'h01 : half_len_ff; // see R6

  // pin synchronisers
  always_ff @(posedge clock_i) begin
    if (clk_en_i) begin
      xs1_ff <= {2'h0, crystal_input_pin_i};
      xs2_ff <= xs1_ff;
      xs3_ff <= xs2_ff;
      ss1_ff[0] <= clock_mode_strap_pins_i;
      ss1_ff[1] <= ss1_ff[0];
      ss1_ff[2] <= ss1_ff[1];
    end
  end

  // strap latch: follows pins while reset is held, frozen afterwards
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      if (clk_en_i && ss1_ff[1] == ss1_ff[2]) begin
        strap_ff <= ss1_ff[2]; // see R1
      end
    end
  end

  // mode and factor follow the latched straps only during reset
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      mode_ff <= strap_mode(strap_ff); // see R1 see R18
      fact_ff <= strap_factor(strap_ff);
    end
  end

  // source state, irrevocable switch to backup
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      src_ff <= clkg_pkg::SRC_NORMAL;
    end else if (clk_en_i) begin
      case (src_ff)
        clkg_pkg::SRC_NORMAL: begin
          if (wdog_ovf || lock_lost) begin
            src_ff <= clkg_pkg::SRC_FREE; // see R11 see R17
          end
        end
        clkg_pkg::SRC_FREE: src_ff <= clkg_pkg::SRC_FREE; // see R12
        default: src_ff <= clkg_pkg::SRC_FREE;
      endcase
    end
  end

  // crystal level and supervisor counters
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      xtal_lvl_ff <= 1'b0;
      wdog_ff <= 5'h00;
      nolock_ff <= 8'h00;
    end else if (clk_en_i) begin
      if (xtal_stable) begin
        xtal_lvl_ff <= xs3_ff[0];
      end
      // cleared by each transition or while the supervisor is off, counts up to WDOG_OVF and holds otherwise
      if (xtal_edge || !sup_act) begin
        wdog_ff <= 5'h00; // see R9
      end else if (wdog_ff != clkg_pkg::WDOG_OVF) begin
        wdog_ff <= wdog_ff + 5'h01; // see R9
      end
      if (xtal_edge || !is_pll) begin
        nolock_ff <= 8'h00;
      end else if (nolock_ff != clkg_pkg::UNLOCK_LIM) begin
        nolock_ff <= nolock_ff + 8'h01;
      end
    end
  end

  // multiplier tracking loop
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      half_len_ff <= clkg_pkg::HALF_RST;
      unit_cnt_ff <= 8'h00;
      win_units_ff <= 8'h00;
      win_tr_ff <= 4'h0;
    end else if (clk_en_i) begin
      half_len_ff <= nxt_half_len;
      unit_cnt_ff <= unit_done ? 8'h00 : unit_cnt_ff + 8'h01;
      // window of F transitions, counting generated half units
      if (win_end) begin
        win_tr_ff <= 4'h0;
        win_units_ff <= 8'(unit_done);
      end else begin
        win_tr_ff <= xtal_edge ? win_tr_ff + 4'h1 : win_tr_ff;
        if (unit_done && win_units_ff != 8'hFF) begin
          win_units_ff <= win_units_ff + 8'h01;
        end
      end
    end
  end

  // registered outputs
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cpu_clk_ff <= 1'b0;
      half_ff <= 1'b0;
      pll_en_ff <= 1'b1;
      amp_en_ff <= 1'b1;
      osc_irq_ff <= 1'b0;
      unl_irq_ff <= 1'b0;
    end else if (clk_en_i) begin
      cpu_clk_ff <= nxt_cpu_clk;
      half_ff <= nxt_cpu_clk != cpu_clk_ff; // see R14
      pll_en_ff <= is_pll || !osc_supervisor_disable_i || !normal; // see R13
      amp_en_ff <= !is_direct; // see R4
      osc_irq_ff <= osc_irq_ff || wdog_ovf; // see R11
      unl_irq_ff <= unl_irq_ff || lock_lost; // see R17
    end
  end

  assign cpu_clk_o = cpu_clk_ff;
  assign half_clock_unit_o = half_ff;
  assign pll_enable_o = pll_en_ff;
  assign osc_amp_enable_o = amp_en_ff;
  assign clock_mode_o = mode_ff;
  assign osc_fail_irq_o = osc_irq_ff;
  assign pll_unlock_irq_o = unl_irq_ff;

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_starve;
    clk_en_i && wdog_ovf;
  endsequence
  sequence s_switched;
    src_ff == clkg_pkg::SRC_FREE && osc_irq_ff;
  endsequence

  AST_STRAP_HOLD: assert property ($past(!sys_rst_i) |-> $stable(mode_ff)) // see R18
    else $error("mode changed outside reset");
  AST_WDOG_SWITCH: assert property (s_starve |=> s_switched) // see R10
    else $error("no switch on supervisor overflow");
  AST_WDOG_CLEAR: assert property (clk_en_i && xtal_edge |=> wdog_ff == 5'h00) // see R9
    else $error("supervisor counter not cleared");
  AST_FREE_STICKY: assert property (src_ff == clkg_pkg::SRC_FREE |=> src_ff == clkg_pkg::SRC_FREE) // see R12
    else $error("backup source left");
  AST_PLL_OFF: assert property (clk_en_i && !is_pll && osc_supervisor_disable_i && normal
    |=> !pll_enable_o) // see R13
    else $error("multiplier not off");
  AST_NO_SUP_PLL: assert property (is_pll |-> !osc_fail_irq_o) // see R8
    else $error("supervisor acted in multiplier mode");
  AST_PRESC_TOG: assert property (clk_en_i && is_presc && normal && !xtal_rise
    ##1 clk_en_i && xtal_rise |=> $changed(cpu_clk_o)) // see R15
    else $error("prescaler edge missing");
  AST_DIRECT_FOLLOW: assert property (clk_en_i && is_direct && normal
    |=> cpu_clk_o == $past(xtal_lvl_ff)) // see R16
    else $error("direct clock does not follow input");
  AST_HALF_MARK: assert property ($past(clk_en_i) |-> half_clock_unit_o == $changed(cpu_clk_o)) // see R14
    else $error("half unit marker wrong");
  AST_UNLOCK: assert property (clk_en_i && lock_lost |=> pll_unlock_irq_o
    && src_ff == clkg_pkg::SRC_FREE) // see R17
    else $error("lock loss not handled");

endmodule : clkg_top

/* clkg_xtal_model.sv */
// crystal or external clock source feeding the clock generator
module clkg_xtal_model (
  // system clock
  input wire logic clock_i,
  // run control and half period in system cycles
  input wire logic run_i,
  input wire logic [7:0] half_i,
  // crystal level
  output logic xtal_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_ff = 8'h00; // cycles spent in this half period
  initial xtal_o = 1'b0;
  // toggle each half period; a failed crystal freezes at its level
  always @(posedge clock_i) begin
    if (run_i) begin
      if (cnt_ff >= half_i - 8'h01) begin
        cnt_ff <= 8'h00;
        xtal_o <= ~xtal_o;
      end else begin
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end
endmodule : clkg_xtal_model

/* clkg_tb.sv */
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
  $display("unexpected at %0t got %h expected %h", $time, got, exp); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // design inputs
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic clk_en_i = 1'b1;
  logic [2:0] straps = 3'h7;
  logic sup_dis = 1'b0;
  // crystal control and design outputs
  logic run = 1'b1;
  logic [7:0] half = 8'h0A;
  logic xtal, cpu_clk, half_unit, pll_en, amp_en, fail_irq, unlock_irq;
  logic [1:0] mode;
  logic [7:0] hist = 8'h00; // recent crystal levels
  int mismatches = 0;
  int comparisons = 0;
  int edges, units;
  clkg_top i_clkg_top (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
    .crystal_input_pin_i(xtal), .clock_mode_strap_pins_i(straps),
    .osc_supervisor_disable_i(sup_dis), .cpu_clk_o(cpu_clk), .half_clock_unit_o(half_unit),
    .pll_enable_o(pll_en), .osc_amp_enable_o(amp_en), .clock_mode_o(mode),
    .osc_fail_irq_o(fail_irq), .pll_unlock_irq_o(unlock_irq));
  clkg_xtal_model i_clkg_xtal_model (.clock_i(clock_i), .run_i(run), .half_i(half),
    .xtal_o(xtal));
  initial forever #5 clock_i = ~clock_i;
  always @(posedge clock_i) hist <= {hist[6:0], xtal};
  // verdict and end of run
  task automatic complete_run();
    if (mismatches == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  // reset with given straps, then flip straps to show they are frozen
  task automatic restart(input logic [2:0] s, input logic dis, input logic [7:0] hp);
    @(posedge clock_i);
    sys_rst_i <= 1'b1;
    straps <= s;
    sup_dis <= dis;
    half <= hp;
    run <= 1'b1;
    repeat (5) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    straps <= ~s;
    repeat (40) @(negedge clock_i);
  endtask : restart
  // count cpu clock changes and half-unit pulses over a window
  task automatic measure(input int cycles);
    logic last;
    edges = 0;
    units = 0;
    last = cpu_clk;
    repeat (cycles) begin
      @(negedge clock_i);
      edges += int'(cpu_clk !== last);
      units += int'(half_unit === 1'b1);
      last = cpu_clk;
    end
  endtask : measure
  // stop the crystal just after one of its edges
  task automatic stop_xtal();
    logic prev;
    prev = xtal;
    @(negedge clock_i);
    while (xtal === prev) @(negedge clock_i);
    @(posedge clock_i);
    run <= 1'b0;
  endtask : stop_xtal
  // direct drive, then crystal failure and irrevocable switchover
  task automatic test_direct();
    restart(3'h3, 1'b0, 8'h0A);
    `CHK(mode, clkg_pkg::MODE_DIRECT)
    `CHK(amp_en, 1'b0)
    `CHK(pll_en, 1'b1)
    repeat (80) begin
      @(negedge clock_i);
      if (hist === 8'h00 || hist === 8'hFF) `CHK(cpu_clk, hist[0])
    end
    measure(200);
    `CHK(edges, 20)
    `CHK(units, 20)
    stop_xtal();
    repeat (12) @(negedge clock_i);
    `CHK(fail_irq, 1'b0)
    repeat (28) @(negedge clock_i);
    `CHK(fail_irq, 1'b1)
    measure(20);
    `CHK(edges, 20)
    @(posedge clock_i);
    run <= 1'b1;
    measure(60);
    `CHK(edges, 60)
    `CHK(fail_irq, 1'b1)
    restart(3'h3, 1'b0, 8'h0A);
    `CHK(fail_irq, 1'b0)
  endtask : test_direct
  // prescaler with supervisor on, then with supervisor off
  task automatic test_presc();
    restart(3'h1, 1'b0, 8'h0A);
    `CHK(mode, clkg_pkg::MODE_PRESC)
    `CHK(amp_en, 1'b1)
    measure(400);
    `CHK(edges, 20)
    `CHK(units, 20)
    restart(3'h1, 1'b1, 8'h0A);
    `CHK(pll_en, 1'b0)
    stop_xtal();
    repeat (80) @(negedge clock_i);
    `CHK(fail_irq, 1'b0)
  endtask : test_presc
  // every multiplier strap, rate for x4 and x8, then lock loss
  task automatic test_pll();
    logic [2:0] s_tab [6] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h2, 3'h0};
    int f_tab [6] = '{4, 3, 8, 5, 10, 4};
    for (int i = 0; i < 6; i++) begin
      restart(s_tab[i], 1'b0, 8'h10);
      `CHK(mode, clkg_pkg::MODE_PLL)
      `CHK(pll_en, 1'b1)
      repeat (500) @(negedge clock_i);
      measure(320);
      if (f_tab[i] == 4 || f_tab[i] == 8) `CHK(edges >= 20 * f_tab[i] - 4 && edges <= 20 * f_tab[i] + 4, 1'b1)
    end
    `CHK(unlock_irq, 1'b0)
    stop_xtal();
    repeat (260) @(negedge clock_i);
    `CHK(unlock_irq, 1'b1)
    `CHK(fail_irq, 1'b0)
    measure(20);
    `CHK(edges, 20)
  endtask : test_pll
  // main sequence
  initial begin
    repeat (5) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    test_direct();
    test_presc();
    test_pll();
    complete_run();
  end
  // watchdog against a hang
  initial begin
    #200000;
    mismatches++;
    complete_run();
  end
endmodule : tb
